// [hdl/crf_consts.vh]
/*
 constants for the cpu register file: view codes, flag bit positions,
 reset values and execution state counts. no surroundings assumed.
*/
`ifndef CRF_CONSTS_VH
`define CRF_CONSTS_VH
`define CRF_VIEW_LONG 2'h0
`define CRF_VIEW_UPPER 2'h1
`define CRF_VIEW_LOWER 2'h2
`define CRF_VIEW_BYTE 2'h3
`define CRF_FLAG_MASK 7
`define CRF_FLAG_UB6 6
`define CRF_FLAG_HALF 5
`define CRF_FLAG_UB4 4
`define CRF_FLAG_NEG 3
`define CRF_FLAG_ZERO 2
`define CRF_FLAG_OVF 1
`define CRF_FLAG_CARRY 0
`define CRF_FLAGS_RESET 8'h80
`define CRF_SP_INDEX 3'h7
`define CRF_OP_LOAD 3'h0
`define CRF_OP_AND 3'h1
`define CRF_OP_OR 3'h2
`define CRF_OP_XOR 3'h3
`define CRF_OP_ARITH 3'h4
`define CRF_OP_NONE 3'h7
`define CRF_STATES_ADD 5'h02
`define CRF_STATES_MUL8 5'h0e
`define CRF_STATES_MUL16 5'h16
`define CRF_STATES_DIV8 5'h0e
`define CRF_STATES_DIV16 5'h16
`define CRF_TIME_ADD 2'h0
`define CRF_TIME_MUL8 2'h1
`define CRF_TIME_MUL16 2'h2
`define CRF_TIME_DIV 2'h3
`define CRF_PC_RESET 24'h000000
`define CRF_PC_STEP 24'h000002
`define CRF_STATES_LEAD 5'h03
`endif

// [hdl/crf_register_file.v]
/*
 cpu architectural register state: eight 32-bit general registers with
 halfword and byte views, stack pointer alias, 24-bit program counter,
 8-bit condition flags, branch condition evaluation and execution timing.
 assumes the core sequencer drives all ports synchronous to clk and holds
 busy-sensitive requests off while busy is high.
*/
`timescale 1ns/10ps
`include "crf_consts.vh"

module crf_register_file (
    input wire clk,
    input wire srst,
    input wire [2:0] rd_a_sel,
    input wire [1:0] rd_a_view,
    input wire rd_a_hi,
    input wire [2:0] rd_b_sel,
    input wire [1:0] rd_b_view,
    input wire rd_b_hi,
    input wire wr_en,
    input wire [2:0] wr_sel,
    input wire [1:0] wr_view,
    input wire wr_hi,
    input wire [31:0] wr_data,
    input wire sp_wr_en,
    input wire [31:0] sp_wr_data,
    input wire pc_load,
    input wire [23:0] pc_load_data,
    input wire pc_advance,
    input wire reset_vector_load,
    input wire [23:0] reset_vector,
    input wire exception_start,
    input wire [2:0] flags_op,
    input wire [7:0] flags_operand,
    input wire [7:0] arith_flags,
    input wire [3:0] arith_update,
    input wire half_carry,
    input wire [3:0] branch_cond,
    input wire op_start,
    input wire [1:0] op_timing,
    input wire sleep_req,
    input wire wake_req,
    output reg [31:0] rd_a_data,
    output reg [31:0] rd_b_data,
    output reg [31:0] stack_pointer_alias,
    output reg [23:0] program_counter,
    output reg [23:0] fetch_addr,
    output reg [7:0] condition_flags,
    output reg mask_active,
    output reg branch_taken,
    output reg busy,
    output reg op_done,
    output reg power_down
);

    reg [31:0] gpr_q [0:7];
    reg [23:0] pc_d;
    reg [7:0] flags_d;
    reg [4:0] state_cnt_q;
    reg [4:0] state_cnt_d;
    reg [1:0] tmr_state_q;
    reg [1:0] tmr_state_d;
    reg done_d;
    reg [4:0] op_len;
    reg cond_d;
    reg [31:0] merged;
    integer i;

    // op timer states, one-hot
    localparam TMR_IDLE = 2'b01;
    localparam TMR_RUN = 2'b10;

    // independent per-port view select
    // narrow views come back zero-extended in the low bits
    function [31:0] view_read;
        input [31:0] word;
        input [1:0] view;
        input hi;
        begin
            case (view)
                // upper half returned in low bits
                `CRF_VIEW_UPPER: view_read = {16'h0000, word[31:16]};
                `CRF_VIEW_LOWER: view_read = {16'h0000, word[15:0]};
                // high or low byte of the lower half
                `CRF_VIEW_BYTE: view_read = hi ? {24'h000000, word[15:8]} :
                    {24'h000000, word[7:0]};
                default: view_read = word;
            endcase
        end
    endfunction

    // merge narrow write into the untouched rest
    // narrow data always sits in the low bits of wr_data
    always @* begin
        merged = gpr_q[wr_sel];
        case (wr_view)
            `CRF_VIEW_UPPER: merged[31:16] = wr_data[15:0];
            `CRF_VIEW_LOWER: merged[15:0] = wr_data[15:0];
            `CRF_VIEW_BYTE: begin
                if (wr_hi) begin
                    merged[15:8] = wr_data[7:0];
                end else begin
                    merged[7:0] = wr_data[7:0];
                end
            end
            default: merged = wr_data;
        endcase
    end

    // general registers carry no reset: architecturally undefined
    always @(posedge clk) begin
        for (i = 0; i < 8; i = i + 1) begin
            // implicit stack pointer update wins over a general write
            if (sp_wr_en && i == `CRF_SP_INDEX) begin
                gpr_q[i] <= sp_wr_data;
            end else if (wr_en && wr_sel == i) begin
                gpr_q[i] <= merged;
            end
        end
    end

    // no write bypass: a read in the cycle of a write to the same
    // register shows the old value, the sequencer must allow for it
    always @(posedge clk) begin
        rd_a_data <= view_read(gpr_q[rd_a_sel], rd_a_view, rd_a_hi);
        rd_b_data <= view_read(gpr_q[rd_b_sel], rd_b_view, rd_b_hi);
        // stack pointer alias of register seven
        stack_pointer_alias <= gpr_q[`CRF_SP_INDEX];
        if (srst) begin
            rd_a_data <= 32'h00000000;
            rd_b_data <= 32'h00000000;
            stack_pointer_alias <= 32'h00000000;
        end
    end

    // program counter next value
    always @* begin
        pc_d = program_counter;
        // vector first, so reset entry cannot be lost to a stray load
        if (reset_vector_load) begin
            pc_d = reset_vector;
        end else if (pc_load) begin
            pc_d = pc_load_data;
        end else if (pc_advance) begin
            // step one 2-byte instruction; wraps inside 16 Mbytes
            pc_d = program_counter + `CRF_PC_STEP;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            program_counter <= `CRF_PC_RESET;
            fetch_addr <= `CRF_PC_RESET;
        end else begin
            program_counter <= pc_d;
            // fetch ignores the lowest bit
            // follows pc_d so both outputs move on one edge
            fetch_addr <= {pc_d[23:1], 1'b0};
        end
    end

    // flags next value
    always @* begin
        flags_d = condition_flags;
        case (flags_op)
            // direct flag instructions; user bits pass freely
            `CRF_OP_LOAD: flags_d = flags_operand;
            `CRF_OP_AND: flags_d = condition_flags & flags_operand;
            `CRF_OP_OR: flags_d = condition_flags | flags_operand;
            `CRF_OP_XOR: flags_d = condition_flags ^ flags_operand;
            `CRF_OP_ARITH: begin
                // n, z, v and c change only where arith_update selects them
                if (arith_update[3]) begin
                    flags_d[`CRF_FLAG_NEG] = arith_flags[`CRF_FLAG_NEG];
                end
                if (arith_update[2]) begin
                    flags_d[`CRF_FLAG_ZERO] = arith_flags[`CRF_FLAG_ZERO];
                end
                if (arith_update[1]) begin
                    flags_d[`CRF_FLAG_OVF] = arith_flags[`CRF_FLAG_OVF];
                end
                if (arith_update[0]) begin
                    flags_d[`CRF_FLAG_CARRY] = arith_flags[`CRF_FLAG_CARRY];
                end
                // carry out of bit 3, 11 or 27 from the datapath
                flags_d[`CRF_FLAG_HALF] = half_carry;
            end
            default: flags_d = condition_flags;
        endcase
        // exception entry forces the mask, overriding any op
        if (exception_start) begin
            flags_d[`CRF_FLAG_MASK] = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            // mask set; other bits undefined, held at zero here
            condition_flags <= `CRF_FLAGS_RESET;
            mask_active <= 1'b1;
        end else begin
            // register layout from bit 7 down to bit 0
            condition_flags <= flags_d;
            // all but non-maskable blocked while set
            mask_active <= flags_d[`CRF_FLAG_MASK];
        end
    end

    // named flag taps keep the branch table readable
    wire flag_n;
    wire flag_z;
    wire flag_v;
    wire flag_c;
    assign flag_n = condition_flags[`CRF_FLAG_NEG];
    assign flag_z = condition_flags[`CRF_FLAG_ZERO];
    assign flag_v = condition_flags[`CRF_FLAG_OVF];
    assign flag_c = condition_flags[`CRF_FLAG_CARRY];

    // branch condition from n, z, v, c
    always @* begin
        case (branch_cond)
            4'h0: cond_d = 1'b1;
            4'h1: cond_d = 1'b0;
            4'h2: cond_d = ~(flag_c | flag_z);
            4'h3: cond_d = flag_c | flag_z;
            4'h4: cond_d = ~flag_c;
            4'h5: cond_d = flag_c;
            4'h6: cond_d = ~flag_z;
            4'h7: cond_d = flag_z;
            4'h8: cond_d = ~flag_v;
            4'h9: cond_d = flag_v;
            4'ha: cond_d = ~flag_n;
            4'hb: cond_d = flag_n;
            4'hc: cond_d = ~(flag_n ^ flag_v);
            4'hd: cond_d = flag_n ^ flag_v;
            4'he: cond_d = ~(flag_z | (flag_n ^ flag_v));
            default: cond_d = flag_z | (flag_n ^ flag_v);
        endcase
    end

    always @(posedge clk) begin
        if (srst) begin
            branch_taken <= 1'b0;
        end else begin
            branch_taken <= cond_d;
        end
    end

    // execution length in states
    // only looked at in the cycle op_start is high
    always @* begin
        case (op_timing)
            `CRF_TIME_ADD: op_len = `CRF_STATES_ADD;
            `CRF_TIME_MUL8: op_len = `CRF_STATES_MUL8;
            `CRF_TIME_MUL16: op_len = `CRF_STATES_MUL16;
            // the one divide code always takes the 16-bit count of 22
            default: op_len = `CRF_STATES_DIV16;
        endcase
    end

    // timer next state; a start while running is dropped
    always @* begin
        tmr_state_d = tmr_state_q;
        state_cnt_d = state_cnt_q;
        done_d = 1'b0;
        case (tmr_state_q)
            TMR_IDLE: begin
                if (op_start) begin
                    // two-state ops end without the run state
                    if (op_len == `CRF_STATES_ADD) begin
                        done_d = 1'b1;
                    end else begin
                        // start and done states are not counted down
                        state_cnt_d = op_len - `CRF_STATES_LEAD;
                        tmr_state_d = TMR_RUN;
                    end
                end
            end
            TMR_RUN: begin
                // done in the last state of the op
                if (state_cnt_q == 5'h00) begin
                    done_d = 1'b1;
                    tmr_state_d = TMR_IDLE;
                end else begin
                    state_cnt_d = state_cnt_q - 5'h01;
                end
            end
            // an illegal code falls back to idle
            default: begin
                tmr_state_d = TMR_IDLE;
            end
        endcase
    end

    // done pulses in the last state of the operation
    always @(posedge clk) begin
        if (srst) begin
            tmr_state_q <= TMR_IDLE;
            state_cnt_q <= 5'h00;
            busy <= 1'b0;
            op_done <= 1'b0;
        end else begin
            tmr_state_q <= tmr_state_d;
            state_cnt_q <= state_cnt_d;
            // busy mirrors the run state
            busy <= (tmr_state_d == TMR_RUN);
            op_done <= done_d;
        end
    end

    // sleep enters power-down until woken
    // wake outranks sleep so a race never strands the core
    always @(posedge clk) begin
        if (srst) begin
            power_down <= 1'b0;
        end else if (wake_req) begin
            power_down <= 1'b0;
        end else if (sleep_req) begin
            power_down <= 1'b1;
        end
    end

endmodule // crf_register_file

// [dv/crf_register_file_sva.sv]
/* checker for crf_register_file: pc, flags and op timing relations.
   sees only the top ports; bound to every instance below. */
`timescale 1ns/10ps
module crf_sva (
    input wire clk,
    input wire srst,
    input wire reset_vector_load,
    input wire [23:0] reset_vector,
    input wire exception_start,
    input wire [2:0] flags_op,
    input wire op_start,
    input wire [1:0] op_timing,
    input wire [23:0] program_counter,
    input wire [23:0] fetch_addr,
    input wire [7:0] condition_flags,
    input wire mask_active,
    input wire busy,
    input wire op_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_reset_flags: assert property ($fell(srst) |-> condition_flags == 8'h80)
        else $error("flags not 0x80 after reset");
    a_mask_mirror: assert property (mask_active == condition_flags[7])
        else $error("mask output differs from flag bit");
    a_fetch_even: assert property (fetch_addr == {program_counter[23:1], 1'b0})
        else $error("fetch address not the even pc");
    a_vector_load: assert property (reset_vector_load |=>
        program_counter == $past(reset_vector)) else $error("pc missed the reset vector");
    a_exc_mask: assert property (exception_start |=> condition_flags[7])
        else $error("mask not set by exception");
    a_flags_hold: assert property (flags_op == 3'h7 && !exception_start
        |=> $stable(condition_flags)) else $error("flags changed without an op");
    a_add_done: assert property (op_start && !busy && op_timing == 2'h0
        |=> op_done && !busy) else $error("add not done in 2 states");
    a_short_op: assert property (op_start && !busy && op_timing == 2'h1
        |=> busy [*8] ##4 busy ##1 (op_done && !busy)) else $error("op not done in 14 states");
    a_long_op: assert property (op_start && !busy && op_timing[1]
        |=> busy [*8] ##12 busy ##1 (op_done && !busy)) else $error("op not done in 22 states");
    c_long_op: cover property (op_start && op_timing == 2'h3);
    c_vector: cover property (reset_vector_load);
    c_exception: cover property (exception_start);
endmodule // crf_sva

bind crf_register_file crf_sva u_sva (.clk, .srst, .reset_vector_load, .reset_vector,
    .exception_start, .flags_op, .op_start, .op_timing, .program_counter, .fetch_addr,
    .condition_flags, .mask_active, .busy, .op_done);

// [dv/crf_register_file_tb.sv]
/* self-checking bench for crf_register_file, inputs driven at negedge.
   assumes the consts header and the checker are compiled alongside. */
`timescale 1ns/10ps
`include "crf_consts.vh"
module crf_register_file_tb;
    logic clk, srst, rd_a_hi, rd_b_hi, wr_en, wr_hi, sp_wr_en, pc_load, pc_advance, half_carry;
    logic reset_vector_load, exception_start, op_start, sleep_req, wake_req, rd_pend;
    logic mask_active, branch_taken, busy, op_done, power_down;
    logic [2:0] rd_a_sel, rd_b_sel, wr_sel, flags_op;
    logic [1:0] rd_a_view, rd_b_view, wr_view, op_timing;
    logic [31:0] wr_data, sp_wr_data, rd_a_data, rd_b_data, stack_pointer_alias, r;
    logic [23:0] pc_load_data, reset_vector, program_counter, fetch_addr;
    logic [7:0] flags_operand, arith_flags, condition_flags;
    logic [3:0] arith_update, branch_cond;
    logic [31:0] mdl [8];
    logic [31:0] expq [$];
    logic [3:0] tk [4] = '{4'h5, 4'h9, 4'h7, 4'hb};
    int st [4] = '{2, 14, 22, 22};
    logic [7:0] fv [2] = '{8'h00, 8'h09};
    logic [15:0] bx [2] = '{16'h5555, 16'ha969};
    int n_fail, num_checks, cyc, k, cnt;
    crf_register_file dut (.clk, .srst, .rd_a_sel, .rd_a_view, .rd_a_hi, .rd_b_sel, .rd_b_view,
        .rd_b_hi, .wr_en, .wr_sel, .wr_view, .wr_hi, .wr_data, .sp_wr_en, .sp_wr_data, .pc_load,
        .pc_load_data, .pc_advance, .reset_vector_load, .reset_vector, .exception_start,
        .flags_op, .flags_operand, .arith_flags, .arith_update, .half_carry, .branch_cond,
        .op_start, .op_timing, .sleep_req, .wake_req, .rd_a_data, .rd_b_data,
        .stack_pointer_alias, .program_counter, .fetch_addr, .condition_flags, .mask_active,
        .branch_taken, .busy, .op_done, .power_down);
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    task automatic final_report();
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1;
        @(negedge clk);
        s = 0;
    endtask
    // read data lands one edge after select; compared just after that edge
    function automatic logic [31:0] vw(logic [2:0] s, logic [1:0] v, logic h);
        if (v == `CRF_VIEW_LONG) return mdl[s];
        if (v == `CRF_VIEW_UPPER) return {16'h0, mdl[s][31:16]};
        if (v == `CRF_VIEW_LOWER) return {16'h0, mdl[s][15:0]};
        return {24'h0, h ? mdl[s][15:8] : mdl[s][7:0]};
    endfunction
    task automatic rd(logic [2:0] s, logic [1:0] v, logic h);
        @(negedge clk);
        {rd_a_sel, rd_a_view, rd_a_hi} = {s, v, h};
        // port b looks at another register through another view
        {rd_b_sel, rd_b_view, rd_b_hi} = {~s, ~v, ~h};
        expq.push_back(vw(s, v, h));
        expq.push_back(vw(~s, ~v, ~h));
        rd_pend = 1;
        @(negedge clk);
        rd_pend = 0;
    endtask
    task automatic wr(logic [2:0] s, logic [1:0] v, logic h, logic [31:0] d);
        @(negedge clk);
        {wr_en, wr_sel, wr_view, wr_hi, wr_data} = {1'b1, s, v, h, d};
        if (v == `CRF_VIEW_LONG) mdl[s] = d;
        else if (v == `CRF_VIEW_UPPER) mdl[s][31:16] = d[15:0];
        else if (v == `CRF_VIEW_LOWER) mdl[s][15:0] = d[15:0];
        else if (h) mdl[s][15:8] = d[7:0];
        else mdl[s][7:0] = d[7:0];
        @(negedge clk);
        wr_en = 0;
    endtask
    task automatic fl(logic [2:0] op, logic [7:0] v, logic [7:0] e);
        @(negedge clk);
        {flags_op, flags_operand} = {op, v};
        @(negedge clk);
        flags_op = `CRF_OP_NONE;
        chk("condition_flags", {24'h0, e}, {24'h0, condition_flags});
    endtask
    task automatic br(logic [3:0] c, logic e);
        @(negedge clk);
        branch_cond = c;
        repeat (2) @(negedge clk);
        chk("branch_taken", {31'h0, e}, {31'h0, branch_taken});
    endtask
    always @(posedge clk) begin
        #1;
        if (rd_pend) begin
            chk("rd_a_data", expq.pop_front(), rd_a_data);
            chk("rd_b_data", expq.pop_front(), rd_b_data);
        end
    end
    // bound well above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        {rd_a_sel, rd_a_view, rd_a_hi, rd_b_sel, rd_b_view, rd_b_hi, wr_en, wr_sel, wr_view} = '0;
        {wr_hi, wr_data, sp_wr_en, sp_wr_data, pc_load, pc_load_data, pc_advance} = '0;
        {reset_vector_load, reset_vector, exception_start, flags_operand, branch_cond} = '0;
        {half_carry, op_start, op_timing, sleep_req, wake_req, rd_pend} = '0;
        {arith_flags, arith_update, flags_op, srst} = {8'h0a, 4'hf, `CRF_OP_NONE, 1'b1};
        k = $urandom(71172);
        repeat (4) @(negedge clk);
        srst = 0;
        chk("condition_flags", 32'h80, {24'h0, condition_flags});
        for (k = 0; k < 8; k++) wr(k[2:0], `CRF_VIEW_LONG, 1'b0, $urandom);
        for (k = 0; k < 24; k++) begin
            r = $urandom;
            wr(r[2:0], r[4:3], r[5], $urandom);
        end
        for (k = 0; k < 32; k++) rd(k[4:2], k[1:0], 1'b0);
        for (k = 0; k < 8; k++) rd(k[2:0], `CRF_VIEW_BYTE, 1'b1);
        @(negedge clk);
        {reset_vector_load, pc_advance, reset_vector} = {2'b11, 24'h123457};
        @(negedge clk);
        reset_vector_load = 0;
        chk("fetch_addr", 32'h123456, {8'h0, fetch_addr});
        @(negedge clk);
        {pc_advance, pc_load, pc_load_data} = {2'b01, 24'hffffff};
        chk("program_counter", 32'h123459, {8'h0, program_counter});
        @(negedge clk);
        {pc_advance, pc_load} = 2'b10;
        @(negedge clk);
        pc_advance = 0;
        chk("program_counter", 32'h1, {8'h0, program_counter});
        @(negedge clk);
        {sp_wr_en, sp_wr_data} = {1'b1, 32'h00fedcb8};
        mdl[7] = 32'h00fedcb8;
        @(negedge clk);
        sp_wr_en = 0;
        repeat (2) @(negedge clk);
        chk("stack_pointer_alias", mdl[7], stack_pointer_alias);
        rd(3'h7, `CRF_VIEW_LONG, 1'b0);
        fl(`CRF_OP_LOAD, 8'h5a, 8'h5a);
        fl(`CRF_OP_AND, 8'h0f, 8'h0a);
        fl(`CRF_OP_OR, 8'h50, 8'h5a);
        fl(`CRF_OP_XOR, 8'hff, 8'ha5);
        fl(`CRF_OP_ARITH, 8'h00, 8'h8a);
        half_carry = 1;
        fl(`CRF_OP_ARITH, 8'h00, 8'haa);
        {arith_flags, arith_update} = {8'h05, 4'h5};
        fl(`CRF_OP_ARITH, 8'h00, 8'haf);
        fl(`CRF_OP_LOAD, 8'h00, 8'h00);
        pulse(exception_start);
        chk("mask_active", 32'h1, {31'h0, mask_active});
        for (k = 0; k < 4; k++) begin
            fl(`CRF_OP_LOAD, 8'h01 << k, 8'h01 << k);
            br(tk[k], 1'b1);
            br(tk[k] - 4'h1, 1'b0);
        end
        for (int j = 0; j < 2; j++) begin
            fl(`CRF_OP_LOAD, fv[j], fv[j]);
            for (k = 0; k < 16; k++) br(k[3:0], bx[j][k]);
        end
        // second start while busy must be ignored
        for (k = 0; k < 4; k++) begin
            @(negedge clk);
            {op_start, op_timing} = {1'b1, k[1:0]};
            cnt = 0;
            while (op_done !== 1'b1 && cnt < 40) begin
                @(negedge clk);
                op_start = (cnt == 0 && k != 0);
                cnt++;
            end
            // the start cycle itself is the first state
            chk("op_states", st[k], cnt + 1);
            @(negedge clk);
            chk("op_done", 32'h0, {31'h0, op_done});
        end
        pulse(sleep_req);
        chk("power_down", 32'h1, {31'h0, power_down});
        pulse(wake_req);
        chk("power_down", 32'h0, {31'h0, power_down});
        final_report();
    end
endmodule // crf_register_file_tb
